// *** common/timer_unit_regs.vh ***
// Register offsets, field positions and reset values of the dual timer/counter unit.
// Assumes an 8-bit register port with byte-wide offsets.
`ifndef TIMER_UNIT_REGS_VH
`define TIMER_UNIT_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_TIMER_MODE_CONTROL      8'h89
`define OFS_TIMER0_COUNT_LOW        8'h8a
`define OFS_TIMER1_COUNT_LOW        8'h8b
`define OFS_TIMER0_COUNT_HIGH       8'h8c
`define OFS_TIMER1_COUNT_HIGH       8'h8d
`define OFS_CLOCK_PRESCALE_CONTROL  8'h8e
`define OFS_TIMER_RUN_CONTROL       8'h88
`define OFS_IRQ_STATUS              8'h80
`define OFS_IRQ_MASK                8'h81
`define OFS_SERVICE_ACK             8'h82

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MODE_U0_LSB                 0
`define MODE_U1_LSB                 4
`define MODE_OP_LOW_BIT             0
`define MODE_OP_HIGH_BIT            1
`define MODE_COUNT_SRC_BIT          2
`define MODE_PIN_QUALIFY_BIT        3
`define RUN_U0_RUN_BIT              4
`define RUN_U0_OVF_BIT              5
`define RUN_U1_RUN_BIT              6
`define RUN_U1_OVF_BIT              7
`define CLOCK_PRESCALE_CONTROL_U0_PRESCALE_BIT       3
`define CLOCK_PRESCALE_CONTROL_U1_PRESCALE_BIT       4
`define IRQ_U0_BIT                  0
`define IRQ_U1_BIT                  1

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define RST_BYTE                    8'h00
`define RST_CLOCK_PRESCALE_CONTROL                   8'h01
`define DIV_FAST                    4'd4
`define DIV_SLOW                    4'd12

`endif

// *** src/prescale_tick.v ***
// Internal tick generator: one-cycle tick every 4 or 12 core clocks.
// Assumes the select input is a register of the same clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "timer_unit_regs.vh"

module prescale_tick (
    input  wire       mclk_i,
    input  wire       rst_b_i,
    input  wire       fast_i,
    output reg        tick_o
);
    reg  [3:0] cnt_q;
    wire [3:0] last_w = fast_i ? (`DIV_FAST - 4'd1) : (`DIV_SLOW - 4'd1);

    // Changing the select mid-period just shortens or stretches one period.
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q  <= 4'h0;
            tick_o <= 1'b0;
        end else if (cnt_q >= last_w) begin
            cnt_q  <= 4'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 4'd1;
            tick_o <= 1'b0;
        end
    end
endmodule // prescale_tick

`default_nettype wire

// *** src/fall_detect.v ***
// Falling-edge detector for an external count pin sampled on the core clock.
// Assumes the pin is already synchronous to mclk_i.
`timescale 1ns/100ps
`default_nettype none

module fall_detect (
    input  wire       mclk_i,
    input  wire       rst_b_i,
    input  wire       pin_i,
    output wire       fall_o
);
    reg s0_q;
    reg s1_q;

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s0_q <= 1'b1;
            s1_q <= 1'b1;
        end else begin
            s0_q <= pin_i;
            s1_q <= s0_q;
        end
    end

    assign fall_o = s1_q & ~s0_q;  // [R16]
endmodule // fall_detect

`default_nettype wire

// *** src/dual_timer_counter_unit.v ***
// Dual 8/16-bit timer/counter with register port and level interrupt.
// Assumes one core clock; count and gate pins are synchronous to it.
//
// Functional notes
// R1: With pin-qualify set a unit advances only while its gate pin is high and its run bit is set.
// R2: With pin-qualify clear a unit advances whenever its run bit is set.
// R3: With count-source clear a unit counts internal prescaled ticks.
// R4: With count-source set a unit counts falling edges on its count pin.
// R5: Mode 00 is an 8-bit counter behind a 5-bit prescaler.
// R6: Mode 01 is a 16-bit counter of the high and low bytes with no prescaler.
// R7: Mode 10 is an 8-bit low byte reloaded from the high byte on overflow.
// R8: In mode 3 unit 0's low byte is an 8-bit counter under unit 0's own controls.
// R9: In mode 3 unit 0's high byte counts internal ticks under unit 1's run bit.
// R10: Unit 1 in mode 3 stops and holds its bytes.
// R11: Unit 1's internal tick is core clock over 4 when its select is 1, over 12 when 0.
// R12: Unit 0's internal tick is core clock over 4 when its select is 1, over 12 when 0.
// R13: Each unit sets an overflow flag on overflow, cleared on service; software may set or clear it.
// R14: Each unit has a software run bit.
// R15: In mode 0 the low five bits of the low byte prescale and the high byte steps on their wrap.
// R16: A count-pin fall is one sample high then one sample low.
`timescale 1ns/100ps
`default_nettype none
`include "timer_unit_regs.vh"

module dual_timer_counter_unit (
    input  wire       mclk_i,
    input  wire       rst_b_i,
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    input  wire       t0_count_pin_i,
    input  wire       t1_count_pin_i,
    input  wire       t0_gate_pin_i,
    input  wire       t1_gate_pin_i,
    input  wire       t0_service_i,
    input  wire       t1_service_i,
    output reg        t0_overflow_o,
    output reg        t1_overflow_o,
    output reg        irq_o
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0] mode_q;
    reg  [7:0] clock_prescale_control_q;
    reg        run0_q;
    reg        run1_q;
    reg        ovf0_q;
    reg        ovf1_q;
    reg  [7:0] tl0_q;
    reg  [7:0] th0_q;
    reg  [7:0] tl1_q;
    reg  [7:0] th1_q;
    reg  [1:0] irq_stat_q;
    reg  [1:0] irq_mask_q;

    // ------------------------------------------------------------
    // Tick sources
    // ------------------------------------------------------------
    wire tick0_w;
    wire tick1_w;
    wire fall0_w;
    wire fall1_w;

    prescale_tick u_tick0 (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .fast_i  (clock_prescale_control_q[`CLOCK_PRESCALE_CONTROL_U0_PRESCALE_BIT]),  // [R12]
        .tick_o  (tick0_w)
    );

    prescale_tick u_tick1 (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .fast_i  (clock_prescale_control_q[`CLOCK_PRESCALE_CONTROL_U1_PRESCALE_BIT]),  // [R11]
        .tick_o  (tick1_w)
    );

    fall_detect u_fall0 (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .pin_i   (t0_count_pin_i),
        .fall_o  (fall0_w)
    );

    fall_detect u_fall1 (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .pin_i   (t1_count_pin_i),
        .fall_o  (fall1_w)
    );

    // ------------------------------------------------------------
    // Step enables
    // ------------------------------------------------------------
    // Run qualification shared by both units.
    function enabled;
        input run;
        input qualify;
        input gate;
        begin
            enabled = run & (~qualify | gate);  // [R1] [R2] [R14]
        end
    endfunction

    wire [3:0] m0_w = mode_q[`MODE_U0_LSB +: 4];
    wire [3:0] m1_w = mode_q[`MODE_U1_LSB +: 4];
    wire [1:0] op0_w = {m0_w[`MODE_OP_HIGH_BIT], m0_w[`MODE_OP_LOW_BIT]};
    wire [1:0] op1_w = {m1_w[`MODE_OP_HIGH_BIT], m1_w[`MODE_OP_LOW_BIT]};

    wire src0_w = m0_w[`MODE_COUNT_SRC_BIT] ? fall0_w : tick0_w;  // [R3] [R4]
    wire src1_w = m1_w[`MODE_COUNT_SRC_BIT] ? fall1_w : tick1_w;  // [R3] [R4]

    wire step0_w = src0_w & enabled(run0_q, m0_w[`MODE_PIN_QUALIFY_BIT], t0_gate_pin_i);
    // Unit 1 stops entirely in mode 3.
    wire step1_w = src1_w & enabled(run1_q, m1_w[`MODE_PIN_QUALIFY_BIT], t1_gate_pin_i)
                   & (op1_w != 2'b11);  // [R10]
    // Unit 0's high byte in mode 3 borrows unit 1's run bit and unit 0's tick.
    wire step0h_w = tick0_w & run1_q & (op0_w == 2'b11);  // [R9]

    // ------------------------------------------------------------
    // Counter next-state
    // ------------------------------------------------------------
    reg  [7:0] tl0_n;
    reg  [7:0] th0_n;
    reg        ov0_n;
    reg        ov0h_n;
    reg  [7:0] tl1_n;
    reg  [7:0] th1_n;
    reg        ov1_n;

    // One unit's count step; in mode 3 it steps only the low byte, the high byte is handled by the caller.
    task count_step;
        input  [1:0] op;
        input  [7:0] lo;
        input  [7:0] hi;
        output [7:0] lo_n;
        output [7:0] hi_n;
        output       ov;
        begin
            lo_n = lo;
            hi_n = hi;
            ov   = 1'b0;
            case (op)
                2'b00: begin
                    lo_n = {lo[7:5], lo[4:0] + 5'd1};  // [R5] [R15]
                    if (lo[4:0] == 5'h1f) begin
                        hi_n = hi + 8'd1;  // [R15]
                        ov   = (hi == 8'hff);
                    end
                end
                2'b01: begin
                    {hi_n, lo_n} = {hi, lo} + 16'd1;  // [R6]
                    ov = ({hi, lo} == 16'hffff);
                end
                2'b10: begin
                    if (lo == 8'hff) begin
                        lo_n = hi;  // [R7]
                        ov   = 1'b1;
                    end else begin
                        lo_n = lo + 8'd1;
                    end
                end
                default: begin
                    lo_n = lo + 8'd1;
                    ov   = (lo == 8'hff);
                end
            endcase
        end
    endtask

    always @* begin
        tl0_n  = tl0_q;
        th0_n  = th0_q;
        ov0_n  = 1'b0;
        ov0h_n = 1'b0;
        tl1_n  = tl1_q;
        th1_n  = th1_q;
        ov1_n  = 1'b0;
        if (step0_w) begin
            count_step(op0_w, tl0_q, th0_q, tl0_n, th0_n, ov0_n);  // [R8]
            if (op0_w == 2'b11) begin
                th0_n = th0_q;
            end
        end
        if (step0h_w) begin
            th0_n  = th0_q + 8'd1;  // [R9]
            ov0h_n = (th0_q == 8'hff);
        end
        if (step1_w) begin
            count_step(op1_w, tl1_q, th1_q, tl1_n, th1_n, ov1_n);
        end
    end

    // In mode 3 unit 0's high byte overflow borrows unit 1's flag.
    wire set0_w = ov0_n;  // [R13]
    wire set1_w = ov1_n | ov0h_n;  // [R13]

    // ------------------------------------------------------------
    // Register port and counter state
    // ------------------------------------------------------------
    wire wr_mode_w = wr_i && (addr_i == `OFS_TIMER_MODE_CONTROL);
    wire wr_tl0_w  = wr_i && (addr_i == `OFS_TIMER0_COUNT_LOW);
    wire wr_tl1_w  = wr_i && (addr_i == `OFS_TIMER1_COUNT_LOW);
    wire wr_th0_w  = wr_i && (addr_i == `OFS_TIMER0_COUNT_HIGH);
    wire wr_th1_w  = wr_i && (addr_i == `OFS_TIMER1_COUNT_HIGH);
    wire wr_ck_w   = wr_i && (addr_i == `OFS_CLOCK_PRESCALE_CONTROL);
    wire wr_run_w  = wr_i && (addr_i == `OFS_TIMER_RUN_CONTROL);
    wire wr_ist_w  = wr_i && (addr_i == `OFS_IRQ_STATUS);
    wire wr_imk_w  = wr_i && (addr_i == `OFS_IRQ_MASK);
    wire wr_ack_w  = wr_i && (addr_i == `OFS_SERVICE_ACK);

    // Service clears come from the pins or the acknowledge register.
    wire svc0_w = t0_service_i | (wr_ack_w & wdata_i[`IRQ_U0_BIT]);
    wire svc1_w = t1_service_i | (wr_ack_w & wdata_i[`IRQ_U1_BIT]);

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_q     <= `RST_BYTE;
            clock_prescale_control_q    <= `RST_CLOCK_PRESCALE_CONTROL;
            run0_q     <= 1'b0;
            run1_q     <= 1'b0;
            ovf0_q     <= 1'b0;
            ovf1_q     <= 1'b0;
            tl0_q      <= `RST_BYTE;
            th0_q      <= `RST_BYTE;
            tl1_q      <= `RST_BYTE;
            th1_q      <= `RST_BYTE;
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
        end else begin
            if (wr_mode_w) begin
                mode_q <= wdata_i;
            end
            if (wr_ck_w) begin
                clock_prescale_control_q <= wdata_i;
            end
            // A software write to a count byte wins over the count step.
            tl0_q <= wr_tl0_w ? wdata_i : tl0_n;
            th0_q <= wr_th0_w ? wdata_i : th0_n;
            tl1_q <= wr_tl1_w ? wdata_i : tl1_n;
            th1_q <= wr_th1_w ? wdata_i : th1_n;
            if (wr_run_w) begin
                run0_q <= wdata_i[`RUN_U0_RUN_BIT];  // [R14]
                run1_q <= wdata_i[`RUN_U1_RUN_BIT];  // [R14]
            end
            // Hardware set beats any clear in the same cycle.
            if (set0_w) begin
                ovf0_q <= 1'b1;  // [R13]
            end else if (wr_run_w) begin
                ovf0_q <= wdata_i[`RUN_U0_OVF_BIT];
            end else if (svc0_w) begin
                ovf0_q <= 1'b0;  // [R13]
            end
            if (set1_w) begin
                ovf1_q <= 1'b1;  // [R13]
            end else if (wr_run_w) begin
                ovf1_q <= wdata_i[`RUN_U1_OVF_BIT];
            end else if (svc1_w) begin
                ovf1_q <= 1'b0;  // [R13]
            end
            if (wr_imk_w) begin
                irq_mask_q <= wdata_i[1:0];
            end
            irq_stat_q <= (irq_stat_q & ~({2{wr_ist_w}} & wdata_i[1:0])) | {set1_w, set0_w};
        end
    end

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    reg [7:0] rmux_w;

    always @* begin
        rmux_w = 8'h00;
        case (addr_i)
            `OFS_TIMER_MODE_CONTROL:     rmux_w = mode_q;
            `OFS_TIMER0_COUNT_LOW:       rmux_w = tl0_q;
            `OFS_TIMER1_COUNT_LOW:       rmux_w = tl1_q;
            `OFS_TIMER0_COUNT_HIGH:      rmux_w = th0_q;
            `OFS_TIMER1_COUNT_HIGH:      rmux_w = th1_q;
            `OFS_CLOCK_PRESCALE_CONTROL: rmux_w = clock_prescale_control_q;
            `OFS_TIMER_RUN_CONTROL:      rmux_w = {ovf1_q, run1_q, ovf0_q, run0_q, 4'h0};
            `OFS_IRQ_STATUS:             rmux_w = {6'h00, irq_stat_q};
            `OFS_IRQ_MASK:               rmux_w = {6'h00, irq_mask_q};
            default:                     rmux_w = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o       <= 8'h00;
            t0_overflow_o <= 1'b0;
            t1_overflow_o <= 1'b0;
            irq_o         <= 1'b0;
        end else begin
            rdata_o       <= rd_i ? rmux_w : 8'h00;
            t0_overflow_o <= ovf0_q;
            t1_overflow_o <= ovf1_q;
            irq_o         <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule // dual_timer_counter_unit

`default_nettype wire

// *** bench/count_pin_model.sv ***
// Far-side model of the count and gate pins of both timer units.
// Assumes pins are synchronous to mclk_i; an idle count pin rests high.
`timescale 1ns/100ps
`default_nettype none
module count_pin_model (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic [1:0] fire_i,
    input  wire logic [1:0] gate_i,
    output logic      [1:0] count_o,
    output logic      [1:0] gate_o
);
    // ----------------------------------------------------------------
    // Pin pulses
    // ----------------------------------------------------------------
    logic [1:0] left_q [0:1];

    // A fire holds the pin low two cycles, so each level is seen by at least one sample.
    always @(posedge mclk_i or negedge rst_b_i) begin
        for (int u = 0; u < 2; u++) begin
            if (!rst_b_i) begin
                left_q[u] <= 2'd0;
            end else if (fire_i[u]) begin
                left_q[u] <= 2'd2;
            end else if (left_q[u] != 2'd0) begin
                left_q[u] <= left_q[u] - 2'd1;
            end
        end
    end
    assign count_o = {left_q[1] == 2'd0, left_q[0] == 2'd0};
    assign gate_o  = gate_i;
endmodule // count_pin_model
`default_nettype wire

// *** bench/dual_timer_counter_unit_monitor.sv ***
// Checker for the register port, overflow flags and interrupt of the timer unit.
// Assumes it is bound to the unit's top module and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module dual_timer_counter_unit_monitor (
    input wire logic       mclk_i,
    input wire logic       rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       t0_count_pin_i,
    input wire logic       t1_count_pin_i,
    input wire logic       t0_gate_pin_i,
    input wire logic       t1_gate_pin_i,
    input wire logic       t0_service_i,
    input wire logic       t1_service_i,
    input wire logic       t0_overflow_o,
    input wire logic       t1_overflow_o,
    input wire logic       irq_o
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic mapped;
    assign mapped = (addr_i inside {8'h80, 8'h81, 8'h82}) || (addr_i >= 8'h88 && addr_i <= 8'h8e);

    chk_rdata_idle:
        assert property (!rd_i [*2] |-> rdata_o == 8'h00) else $error("read data not idle");
    chk_unmapped_zero:
        assert property (rd_i && !mapped |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    chk_mode_back:
        assert property (wr_i && addr_i == 8'h89 ##1 rd_i && addr_i == 8'h89 |=> rdata_o == $past(wdata_i, 2))
            else $error("mode register readback wrong");
    chk_run_back:
        assert property (wr_i && addr_i == 8'h88 ##1 rd_i && addr_i == 8'h88
            |=> (rdata_o & 8'h50) == ($past(wdata_i, 2) & 8'h50)) else $error("run bits readback wrong");
    chk_flag_set0:
        assert property (wr_i && addr_i == 8'h88 && wdata_i[5] && !t0_service_i |-> ##2 t0_overflow_o)
            else $error("unit 0 flag not set by software");
    chk_flag_set1:
        assert property (wr_i && addr_i == 8'h88 && wdata_i[7] && !t1_service_i |-> ##2 t1_overflow_o)
            else $error("unit 1 flag not set by software");
    chk_service_clear:
        assert property (t0_service_i && !wr_i |-> ##2 !t0_overflow_o) else $error("service left flag set");
    chk_ack_clear:
        assert property (wr_i && addr_i == 8'h82 && wdata_i[0] |-> ##2 !t0_overflow_o)
            else $error("acknowledge left flag set");
    chk_mask_off:
        assert property (wr_i && addr_i == 8'h81 && wdata_i[1:0] == 2'b00 ##1 !(wr_i && addr_i == 8'h81)
            |-> ##1 !irq_o) else $error("interrupt high while masked");

    cov_irq: cover property ($rose(irq_o));
    cov_ovf0: cover property ($rose(t0_overflow_o));
    cov_ovf1: cover property ($rose(t1_overflow_o));
endmodule // dual_timer_counter_unit_monitor
`default_nettype wire

// *** bench/tb_dual_timer_counter_unit.sv ***
// Self-checking bench of the dual timer unit: registers, pin counting, prescale, flags, interrupt.
// Assumes the pin model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb_dual_timer_counter_unit;
    typedef struct packed {
        logic u; logic [3:0] nib; logic run; logic gate; logic [7:0] lo; logic [7:0] hi;
        logic [3:0] n; logic [7:0] elo; logic [7:0] ehi; logic eov;
    } row_t;
    logic       mclk_i, rst_b_i, wr_i, rd_i, irq;
    logic [7:0] addr_i, wdata_i, rdata_o, rv;
    logic [1:0] fire, gate, svc, cpin, gpin, ovf;
    int         bad_count, cmp_count;
    row_t       rows [9];
    row_t       r;

    dual_timer_counter_unit i_dual_timer_counter_unit (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .t0_count_pin_i(cpin[0]),
        .t1_count_pin_i(cpin[1]), .t0_gate_pin_i(gpin[0]), .t1_gate_pin_i(gpin[1]), .t0_service_i(svc[0]),
        .t1_service_i(svc[1]), .t0_overflow_o(ovf[0]), .t1_overflow_o(ovf[1]), .irq_o(irq));
    count_pin_model i_count_pin_model (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .fire_i(fire), .gate_i(gate),
        .count_o(cpin), .gate_o(gpin));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Called just after a rising edge; returns on one, with an idle cycle so no strobe is set twice.
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic rd);
        addr_i <= a;
        if (w) begin
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge mclk_i);
            wr_i <= 1'b0;
        end
        if (rd) begin
            rd_i <= 1'b1;
            @(posedge mclk_i);
            rd_i <= 1'b0;
            #1 rv = rdata_o;
        end
        @(posedge mclk_i);
    endtask
    task automatic pulses(input logic u, input logic [3:0] n);
        repeat (n) begin
            fire[u] <= 1'b1;
            @(posedge mclk_i);
            fire[u] <= 1'b0;
            repeat (3) @(posedge mclk_i);
        end
        repeat (6) @(posedge mclk_i);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        bad_count++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        rst_b_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; addr_i = 8'h00; wdata_i = 8'h00;
        fire = 2'b00; gate = 2'b00; svc = 2'b00; bad_count = 0; cmp_count = 0;
        rows[0] = '{1'b0, 4'h5, 1'b1, 1'b0, 8'hfe, 8'h00, 4'd3, 8'h01, 8'h01, 1'b0};
        rows[1] = '{1'b0, 4'h6, 1'b1, 1'b0, 8'hfe, 8'ha0, 4'd3, 8'ha1, 8'ha0, 1'b1};
        rows[2] = '{1'b0, 4'h4, 1'b1, 1'b0, 8'h1e, 8'h05, 4'd2, 8'h00, 8'h06, 1'b0};
        rows[3] = '{1'b0, 4'hd, 1'b1, 1'b0, 8'h00, 8'h00, 4'd3, 8'h00, 8'h00, 1'b0};
        rows[4] = '{1'b0, 4'hd, 1'b1, 1'b1, 8'h00, 8'h00, 4'd3, 8'h03, 8'h00, 1'b0};
        rows[5] = '{1'b0, 4'h5, 1'b1, 1'b0, 8'h00, 8'h00, 4'd3, 8'h03, 8'h00, 1'b0};
        rows[6] = '{1'b0, 4'h5, 1'b0, 1'b0, 8'h00, 8'h00, 4'd3, 8'h00, 8'h00, 1'b0};
        rows[7] = '{1'b1, 4'h5, 1'b1, 1'b0, 8'hff, 8'hff, 4'd2, 8'h01, 8'h00, 1'b1};
        rows[8] = '{1'b1, 4'h6, 1'b1, 1'b0, 8'hfe, 8'h10, 4'd3, 8'h11, 8'h10, 1'b1};
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        for (int a = 8'h80; a <= 8'h8e; a++) begin
            if (a == 8'h80 || a == 8'h81 || a >= 8'h88) begin
                acc(a[7:0], 8'h00, 1'b0, 1'b1);
                chk(rv, (a == 8'h8e) ? 8'h01 : 8'h00);
            end
        end
        acc(8'h90, 8'h5a, 1'b1, 1'b1);
        chk(rv, 8'h00);
        acc(8'h89, 8'ha5, 1'b1, 1'b1);
        chk(rv, 8'ha5);
        $display("reset and register test done");
        foreach (rows[i]) begin
            r = rows[i];
            acc(8'h88, 8'h00, 1'b1, 1'b0);
            acc(8'h89, r.u ? {r.nib, 4'h0} : {4'h0, r.nib}, 1'b1, 1'b0);
            acc(r.u ? 8'h8b : 8'h8a, r.lo, 1'b1, 1'b0);
            acc(r.u ? 8'h8d : 8'h8c, r.hi, 1'b1, 1'b0);
            gate[r.u] <= r.gate;
            acc(8'h88, {1'b0, r.run & r.u, 1'b0, r.run & ~r.u, 4'h0}, 1'b1, 1'b1);
            pulses(r.u, r.n);
            #1 chk({7'h0, ovf[r.u]}, {7'h0, r.eov});
            @(posedge mclk_i);
            acc(r.u ? 8'h8b : 8'h8a, 8'h00, 1'b0, 1'b1);
            chk(rv, r.elo);
            acc(r.u ? 8'h8d : 8'h8c, 8'h00, 1'b0, 1'b1);
            chk(rv, r.ehi);
            $display("row %0d done", i);
        end
        for (int s = 0; s < 2; s++) begin
            acc(8'h88, 8'h00, 1'b1, 1'b0);
            acc(8'h8e, s ? 8'h19 : 8'h01, 1'b1, 1'b0);
            acc(8'h89, 8'h11, 1'b1, 1'b0);
            acc(8'h8a, 8'h00, 1'b1, 1'b0);
            acc(8'h8b, 8'h00, 1'b1, 1'b0);
            acc(8'h88, 8'h50, 1'b1, 1'b0);
            repeat (120) @(posedge mclk_i);
            acc(8'h88, 8'h00, 1'b1, 1'b0);
            for (int u = 0; u < 2; u++) begin
                acc(u ? 8'h8b : 8'h8a, 8'h00, 1'b0, 1'b1);
                chk({7'h0, rv >= (s ? 30 : 10) && rv <= (s ? 31 : 11)}, 8'h01);
            end
        end
        $display("prescale test done");
        acc(8'h8e, 8'h09, 1'b1, 1'b0);
        acc(8'h89, 8'h33, 1'b1, 1'b0);
        for (int a = 8'h8a; a <= 8'h8d; a++) acc(a[7:0], 8'h00, 1'b1, 1'b0);
        acc(8'h88, 8'h40, 1'b1, 1'b0);
        repeat (120) @(posedge mclk_i);
        acc(8'h88, 8'h00, 1'b1, 1'b0);
        acc(8'h8c, 8'h00, 1'b0, 1'b1);
        chk({7'h0, rv >= 30 && rv <= 31}, 8'h01);
        for (int a = 8'h8a; a <= 8'h8d; a++) begin
            if (a != 8'h8c) begin
                acc(a[7:0], 8'h00, 1'b0, 1'b1);
                chk(rv, 8'h00);
            end
        end
        acc(8'h89, 8'h37, 1'b1, 1'b0);
        acc(8'h88, 8'h10, 1'b1, 1'b0);
        pulses(1'b0, 4'd2);
        acc(8'h8a, 8'h00, 1'b0, 1'b1);
        chk(rv, 8'h02);
        $display("mode 3 test done");
        acc(8'h88, 8'h00, 1'b1, 1'b0);
        acc(8'h80, 8'hff, 1'b1, 1'b0);
        acc(8'h81, 8'h01, 1'b1, 1'b0);
        acc(8'h89, 8'h05, 1'b1, 1'b0);
        acc(8'h8a, 8'hff, 1'b1, 1'b0);
        acc(8'h8c, 8'hff, 1'b1, 1'b0);
        acc(8'h88, 8'h10, 1'b1, 1'b0);
        pulses(1'b0, 4'd1);
        #1 chk({6'h0, irq, ovf[0]}, 8'h03);
        @(posedge mclk_i);
        svc[0] <= 1'b1;
        @(posedge mclk_i);
        svc[0] <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1 chk({6'h0, irq, ovf[0]}, 8'h02);
        @(posedge mclk_i);
        acc(8'h80, 8'h01, 1'b1, 1'b0);
        #1 chk({7'h0, irq}, 8'h00);
        @(posedge mclk_i);
        acc(8'h8a, 8'hff, 1'b1, 1'b0);
        acc(8'h8c, 8'hff, 1'b1, 1'b0);
        acc(8'h81, 8'h00, 1'b1, 1'b0);
        pulses(1'b0, 4'd1);
        #1 chk({6'h0, irq, ovf[0]}, 8'h01);
        @(posedge mclk_i);
        acc(8'h81, 8'h01, 1'b1, 1'b0);
        #1 chk({7'h0, irq}, 8'h01);
        @(posedge mclk_i);
        acc(8'h82, 8'h01, 1'b1, 1'b0);
        #1 chk({7'h0, ovf[0]}, 8'h00);
        @(posedge mclk_i);
        acc(8'h88, 8'ha0, 1'b1, 1'b0);
        #1 chk({6'h0, ovf}, 8'h03);
        @(posedge mclk_i);
        acc(8'h80, 8'h00, 1'b0, 1'b1);
        chk(rv, 8'h01);
        $display("interrupt test done");
        end_sim();
    end
endmodule // tb_dual_timer_counter_unit

bind dual_timer_counter_unit dual_timer_counter_unit_monitor i_dual_timer_counter_unit_monitor (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .t0_count_pin_i(t0_count_pin_i), .t1_count_pin_i(t1_count_pin_i),
    .t0_gate_pin_i(t0_gate_pin_i), .t1_gate_pin_i(t1_gate_pin_i), .t0_service_i(t0_service_i),
    .t1_service_i(t1_service_i), .t0_overflow_o(t0_overflow_o), .t1_overflow_o(t1_overflow_o), .irq_o(irq_o));
`default_nettype wire
